/* logic/tdcm_top.sv */
`timescale 1ns/1ps
`include "tdcm_defines.svh"

module tdcm_top (
  // Clock, reset, enable
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // Register port behind the serial interface
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire tdcm_pkg::tdcm_byte_type reg_addr_i,
  input wire tdcm_pkg::tdcm_byte_type reg_wdata_i,
  output tdcm_pkg::tdcm_byte_type reg_rdata_o,
  // Host converter codes
  input wire logic dac_a_we_i,
  input wire logic dac_b_we_i,
  input wire tdcm_pkg::tdcm_code_type dac_wdata_i,
  // Load pin, active low
  input wire logic output_load_strobe_n_i,
  // Measurements, quarter-degree two's complement
  input wire tdcm_pkg::tdcm_temp_type int_temp_i,
  input wire logic int_temp_valid_i,
  input wire tdcm_pkg::tdcm_temp_type ext_temp_i,
  input wire logic ext_temp_valid_i,
  // Converter controls
  output tdcm_pkg::tdcm_code_type dac_a_code_o,
  output tdcm_pkg::tdcm_code_type dac_b_code_o,
  output logic [3:0] span_double_o,
  output logic internal_reference_select_o,
  output logic tracking_resolution_select_o
);
  import tdcm_pkg::*;

  function automatic logic wr_hit(input tdcm_byte_type addr);
    wr_hit = ce_i && reg_wr_i && (reg_addr_i == addr);
  endfunction

  tdcm_byte_type ctrl3_reg;
  tdcm_byte_type chan_cfg_reg;
  tdcm_byte_type load_cfg_reg;
  tdcm_byte_type int_ofs_reg;
  tdcm_byte_type ext_ofs_reg;
  tdcm_code_type host_a_reg;
  tdcm_code_type host_b_reg;
  logic load_pin_reg;
  tdcm_code_type calc_a;
  tdcm_code_type calc_b;
  tdcm_res_type res_sel;
  logic trk_int;
  logic trk_ext;
  logic pin_fall;
  logic load_cmd;

  assign trk_int = ctrl3_reg[`TDCM_BIT_INT_TRK];
  assign trk_ext = ctrl3_reg[`TDCM_BIT_EXT_TRK];
  assign res_sel = ctrl3_reg[`TDCM_BIT_RES_SEL] ? TDCM_RES_10 : TDCM_RES_8;
  assign pin_fall = load_pin_reg && !output_load_strobe_n_i;
  // Software load is a self-clearing command, so it never reads back as set
  assign load_cmd = pin_fall || (wr_hit(`TDCM_ADDR_LOAD_CFG)
                    && reg_wdata_i[`TDCM_BIT_SW_LOAD]);

  //////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl3_reg <= `TDCM_RST_CTRL3;
      chan_cfg_reg <= `TDCM_RST_CHAN_CFG;
      load_cfg_reg <= `TDCM_RST_LOAD_CFG;
    end else begin
      if (wr_hit(`TDCM_ADDR_CTRL3)) begin
        ctrl3_reg <= reg_wdata_i;
      end
      if (wr_hit(`TDCM_ADDR_CHAN_CFG)) begin
        chan_cfg_reg <= reg_wdata_i;
      end
      if (wr_hit(`TDCM_ADDR_LOAD_CFG)) begin
        load_cfg_reg <= reg_wdata_i & ~(8'h01 << `TDCM_BIT_SW_LOAD);
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      int_ofs_reg <= `TDCM_RST_OFS;
      ext_ofs_reg <= `TDCM_RST_OFS;
    end else begin
      if (wr_hit(`TDCM_ADDR_INT_OFS)) begin
        int_ofs_reg <= reg_wdata_i;
      end
      if (wr_hit(`TDCM_ADDR_EXT_OFS)) begin
        ext_ofs_reg <= reg_wdata_i;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= `TDCM_RDATA_NONE;
    end else if (ce_i && reg_rd_i) begin
      case (reg_addr_i)
        `TDCM_ADDR_CTRL3: begin
          reg_rdata_o <= ctrl3_reg;
        end
        `TDCM_ADDR_CHAN_CFG: begin
          reg_rdata_o <= chan_cfg_reg;
        end
        `TDCM_ADDR_LOAD_CFG: begin
          reg_rdata_o <= load_cfg_reg;
        end
        `TDCM_ADDR_INT_OFS: begin
          reg_rdata_o <= int_ofs_reg;
        end
        `TDCM_ADDR_EXT_OFS: begin
          reg_rdata_o <= ext_ofs_reg;
        end
        default: begin
          reg_rdata_o <= `TDCM_RDATA_NONE;
        end
      endcase
    end
  end

  assign span_double_o = chan_cfg_reg[`TDCM_SPAN_MSB:0];
  assign internal_reference_select_o = load_cfg_reg[`TDCM_BIT_REF_SEL];
  assign tracking_resolution_select_o = ctrl3_reg[`TDCM_BIT_RES_SEL];

  //////////////////////////////////////////////////////////////////////////////
  // Host codes and load pin

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      host_a_reg <= `TDCM_RST_CODE;
      host_b_reg <= `TDCM_RST_CODE;
      load_pin_reg <= 1'b1;
    end else if (ce_i) begin
      load_pin_reg <= output_load_strobe_n_i;
      if (dac_a_we_i) begin
        host_a_reg <= dac_wdata_i;
      end
      if (dac_b_we_i) begin
        host_b_reg <= dac_wdata_i;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Temperature-to-code mapping

  tdcm_code_calc u_calc_a (
    .temp_i(int_temp_i),
    .offset_i(int_ofs_reg),
    .res_i(res_sel),
    .code_o(calc_a)
  );

  tdcm_code_calc u_calc_b (
    .temp_i(ext_temp_i),
    .offset_i(ext_ofs_reg),
    .res_i(res_sel),
    .code_o(calc_b)
  );

  // Tracking owns its channel; a load then leaves that channel alone
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dac_a_code_o <= `TDCM_RST_CODE;
    end else if (ce_i) begin
      if (trk_int) begin
        if (int_temp_valid_i) begin
          dac_a_code_o <= calc_a;
        end
      end else if (load_cmd) begin
        dac_a_code_o <= host_a_reg;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dac_b_code_o <= `TDCM_RST_CODE;
    end else if (ce_i) begin
      if (trk_ext) begin
        if (ext_temp_valid_i) begin
          dac_b_code_o <= calc_b;
        end
      end else if (load_cmd) begin
        dac_b_code_o <= host_b_reg;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  a_track_int_reload: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    ce_i && trk_int && int_temp_valid_i |=> dac_a_code_o == $past(calc_a))
    else $error("channel A missed tracking reload");

  a_track_ext_reload: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    ce_i && trk_ext && ext_temp_valid_i |=> dac_b_code_o == $past(calc_b))
    else $error("channel B missed tracking reload");

  a_step_eight_bit: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    ce_i && trk_int && int_temp_valid_i && res_sel == TDCM_RES_8
    && int_temp_i == {int_ofs_reg + 8'h05, 2'b00} && !int_ofs_reg[7] && int_ofs_reg < 8'h70
    |=> dac_a_code_o == 10'h014)
    else $error("8-bit step not one per degree");

  a_res_default: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    $rose(rstn_i) |-> !tracking_resolution_select_o)
    else $error("resolution not 8-bit after reset");

  a_ref_select: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    wr_hit(`TDCM_ADDR_LOAD_CFG)
    |=> internal_reference_select_o == $past(reg_wdata_i[`TDCM_BIT_REF_SEL]))
    else $error("reference select not taken");

  a_span_bits: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    wr_hit(`TDCM_ADDR_CHAN_CFG) |=> span_double_o == $past(reg_wdata_i[`TDCM_SPAN_MSB:0]))
    else $error("span bits not taken");

  a_offset_read: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    wr_hit(`TDCM_ADDR_INT_OFS) ##1 !wr_hit(`TDCM_ADDR_INT_OFS)
    ##1 (ce_i && reg_rd_i && !reg_wr_i && reg_addr_i == `TDCM_ADDR_INT_OFS)
    |=> reg_rdata_o == $past(reg_wdata_i, 3))
    else $error("offset register lost data");

  a_below_zero: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    ce_i && trk_int && int_temp_valid_i
    && $signed(int_temp_i) < $signed({int_ofs_reg, 2'b00}) |=> dac_a_code_o == 10'h000)
    else $error("code wrapped below zero-code temperature");

  a_dead_band: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    ce_i && trk_int && int_temp_valid_i && int_ofs_reg == 8'hD8 && res_sel == TDCM_RES_8
    |=> dac_a_code_o <= 10'h29C)
    else $error("code entered dead band");

  a_hold_no_load: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    ce_i && !trk_int && !load_cmd |=> $stable(dac_a_code_o))
    else $error("host code reached output without load");

  c_pin_load: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
    ce_i && pin_fall && !trk_int);
  c_track_10: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
    ce_i && trk_ext && ext_temp_valid_i && res_sel == TDCM_RES_10);
  c_clamp_zero: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
    ce_i && trk_int && int_temp_valid_i && calc_a == 10'h000);
endmodule

/* logic/tdcm_defines.svh */
`ifndef TDCM_DEFINES_SVH
`define TDCM_DEFINES_SVH

// Register addresses
`define TDCM_ADDR_CTRL3 8'h1A
`define TDCM_ADDR_CHAN_CFG 8'h1B
`define TDCM_ADDR_LOAD_CFG 8'h1C
`define TDCM_ADDR_INT_OFS 8'h21
`define TDCM_ADDR_EXT_OFS 8'h22

// Field positions
`define TDCM_BIT_RES_SEL 1
`define TDCM_BIT_INT_TRK 5
`define TDCM_BIT_EXT_TRK 6
`define TDCM_BIT_REF_SEL 4
`define TDCM_BIT_SW_LOAD 3
`define TDCM_SPAN_MSB 3

// Reset values
`define TDCM_RST_CTRL3 8'h00
`define TDCM_RST_CHAN_CFG 8'h00
`define TDCM_RST_LOAD_CFG 8'h00
`define TDCM_RST_OFS 8'hD8
`define TDCM_RST_CODE 10'h000
`define TDCM_RDATA_NONE 8'h00

// Code limits
`define TDCM_CODE_MAX10 10'h3FF
`define TDCM_CODE_MAX8 8'hFF
`define TDCM_CODE_ZERO 10'h000

`endif

/* logic/tdcm_pkg.sv */
package tdcm_pkg;
  typedef logic [9:0] tdcm_code_type;
  typedef logic [9:0] tdcm_temp_type;
  typedef logic [7:0] tdcm_byte_type;
  typedef enum logic {TDCM_RES_8, TDCM_RES_10} tdcm_res_type;
endpackage

/* logic/tdcm_code_calc.sv */
`timescale 1ns/1ps
`include "tdcm_defines.svh"

module tdcm_code_calc (
  // Measurement and settings
  input wire tdcm_pkg::tdcm_temp_type temp_i,
  input wire tdcm_pkg::tdcm_byte_type offset_i,
  input wire tdcm_pkg::tdcm_res_type res_i,
  // Resulting code; 8-bit codes left-justified on the 10-bit converter, 10-bit codes use all bits
  output tdcm_pkg::tdcm_code_type code_o
);
  import tdcm_pkg::*;

  logic [11:0] diff;
  logic [9:0] whole;

  // Temperature is in quarter degrees; offset is whole degrees, scaled to match
  assign diff = {{2{temp_i[9]}}, temp_i} - {{2{offset_i[7]}}, offset_i, 2'b00};
  assign whole = diff[11:2];

  always_comb begin
    code_o = `TDCM_CODE_ZERO;
    if (diff[11]) begin
      code_o = `TDCM_CODE_ZERO;
    end else if (res_i == TDCM_RES_10) begin
      // Saturating keeps the code in place at the top of the range
      code_o = (diff > {2'h0, `TDCM_CODE_MAX10}) ? `TDCM_CODE_MAX10 : diff[9:0];
    end else begin
      // One step per degree: 8-bit code sits in the upper bits of the converter
      code_o = (whole > {2'h0, `TDCM_CODE_MAX8}) ? {`TDCM_CODE_MAX8, 2'b00}
                                                 : {whole[7:0], 2'b00};
    end
  end
endmodule

/* test/tdcm_host_model.sv */
`timescale 1ns/1ps
module tdcm_host_model (
  // Clock and read data
  input wire logic clk_i,
  input wire tdcm_pkg::tdcm_byte_type rdata_i,
  // Register requests
  output logic wr_o,
  output logic rd_o,
  output tdcm_pkg::tdcm_byte_type addr_o,
  output tdcm_pkg::tdcm_byte_type wdata_o
);
  import tdcm_pkg::*;
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end
  ////////////////////////////////////////////////////////////////
  // Data is scrambled after release so a stale byte never looks valid
  task wr(input tdcm_byte_type a, input tdcm_byte_type d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(posedge clk_i);
    #1;
    wr_o = 1'b0;
    wdata_o = ~d;
  endtask
  task rd(input tdcm_byte_type a, output tdcm_byte_type d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    rd_o = 1'b1;
    @(posedge clk_i);
    #1;
    rd_o = 1'b0;
    d = rdata_i;
  endtask
endmodule

/* test/thermal_dac_code_mapper_tb.sv */
`timescale 1ns/1ps
module thermal_dac_code_mapper_tb;
  import tdcm_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic a_we = 1'b0;
  logic b_we = 1'b0;
  logic ld_n = 1'b1;
  logic iv = 1'b0;
  logic ev = 1'b0;
  logic ce = 1'b1;
  logic wr, rd, iref, res10;
  logic [3:0] span;
  tdcm_byte_type addr, wdata, rdata, rv;
  tdcm_code_type wd = 10'h000;
  tdcm_code_type code_a, code_b;
  tdcm_temp_type it = 10'h000;
  tdcm_temp_type et = 10'h000;
  int err_count = 0;
  int comparisons = 0;
  int cyc = 0;
  always #12.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////
  tdcm_top tdcm_top_inst (
    .core_clk_i(clk), .rstn_i(rst_n), .ce_i(ce),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .dac_a_we_i(a_we), .dac_b_we_i(b_we),
    .dac_wdata_i(wd), .output_load_strobe_n_i(ld_n),
    .int_temp_i(it), .int_temp_valid_i(iv), .ext_temp_i(et),
    .ext_temp_valid_i(ev), .dac_a_code_o(code_a), .dac_b_code_o(code_b),
    .span_double_o(span), .internal_reference_select_o(iref),
    .tracking_resolution_select_o(res10)
  );
  tdcm_host_model tdcm_host_model_inst (
    .clk_i(clk), .rdata_i(rdata), .wr_o(wr), .rd_o(rd),
    .addr_o(addr), .wdata_o(wdata)
  );
  ////////////////////////////////////////////////////////////////
  task chk(input string n, input tdcm_code_type e, input tdcm_code_type g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task close_out;
    $display("Checks %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task wr_reg(input tdcm_byte_type a, input tdcm_byte_type d);
    tdcm_host_model_inst.wr(a, d);
  endtask
  task rdc(input tdcm_byte_type a, input tdcm_byte_type e);
    tdcm_host_model_inst.rd(a, rv);
    chk("reg_rdata", {2'h0, e}, {2'h0, rv});
  endtask
  // One measurement pulse, code checked one cycle later
  task trk(input logic ch, input tdcm_temp_type t, input tdcm_code_type e);
    @(posedge clk);
    #1;
    it = ch ? it : t;
    et = ch ? t : et;
    iv = ~ch;
    ev = ch;
    @(posedge clk);
    #1;
    iv = 1'b0;
    ev = 1'b0;
    chk(ch ? "dac_b_code" : "dac_a_code", e, ch ? code_b : code_a);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    #1;
    rst_n = 1'b1;
    rdc(8'h1A, 8'h00);
    rdc(8'h1B, 8'h00);
    rdc(8'h1C, 8'h00);
    rdc(8'h21, 8'hD8);
    rdc(8'h22, 8'hD8);
    rdc(8'h30, 8'h00);
    chk("res_sel", 10'h000, {9'h0, res10});
    $display("Test reset done");
    wr_reg(8'h1C, 8'h10);
    chk("ref_sel", 10'h001, {9'h0, iref});
    wr_reg(8'h1B, 8'h0A);
    chk("span", 10'h00A, {6'h0, span});
    wr_reg(8'h1B, 8'h05);
    chk("span", 10'h005, {6'h0, span});
    $display("Test config done");
    @(posedge clk);
    #1;
    a_we = 1'b1;
    wd = 10'h155;
    @(posedge clk);
    #1;
    a_we = 1'b0;
    ld_n = 1'b0;
    chk("dac_a_code", 10'h000, code_a);
    @(posedge clk);
    #1;
    ld_n = 1'b1;
    chk("dac_a_code", 10'h155, code_a);
    b_we = 1'b1;
    wd = 10'h2AA;
    @(posedge clk);
    #1;
    b_we = 1'b0;
    chk("dac_b_code", 10'h000, code_b);
    wr_reg(8'h1C, 8'h18);
    chk("dac_b_code", 10'h2AA, code_b);
    rdc(8'h1C, 8'h10);
    $display("Test load done");
    wr_reg(8'h1A, 8'h60);
    trk(1'b0, 10'h064, 10'h104);
    trk(1'b0, 10'h1FC, 10'h29C);
    trk(1'b0, 10'h338, 10'h000);
    trk(1'b1, 10'h338, 10'h000);
    trk(1'b1, 10'h064, 10'h104);
    wr_reg(8'h1A, 8'h62);
    chk("res_sel", 10'h001, {9'h0, res10});
    trk(1'b0, 10'h065, 10'h105);
    trk(1'b1, 10'h065, 10'h105);
    wr_reg(8'h21, 8'h80);
    rdc(8'h21, 8'h80);
    trk(1'b0, 10'h1FF, 10'h3FF);
    wr_reg(8'h1A, 8'h60);
    trk(1'b0, 10'h1FF, 10'h3FC);
    wr_reg(8'h22, 8'h0A);
    trk(1'b1, 10'h028, 10'h000);
    trk(1'b1, 10'h02C, 10'h004);
    chk("dac_a_code", 10'h3FC, code_a);
    wr_reg(8'h21, 8'h0A);
    trk(1'b0, 10'h03C, 10'h014);
    $display("Test tracking done");
    // With the enable low nothing may move, not even a measurement
    ce = 1'b0;
    wr_reg(8'h1B, 8'h0F);
    chk("span", 10'h005, {6'h0, span});
    trk(1'b0, 10'h064, 10'h014);
    ce = 1'b1;
    $display("Test enable done");
    close_out();
  end
endmodule
